// ---- design/video_scaler.sv ----
// Purpose: Source select, start line and vertical scaling of the video scaler.
// Assumes: Port inputs synchronous to clk_sys; line_clock is a byte tick held until in_ready is high.
// Notes: Output bytes carry a column index so that mirroring needs no second line store.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

module scaler_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 4
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // Fill level.
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_check
      $error("scaler_fifo depth must be a power of two of at least 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   assign level = wr_q - rd_q;
   assign in_ready = level != (AW+1)'(DEPTH);
   assign out_valid = level != '0;
   assign out_data = mem[rd_q[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule

module video_scaler #(
   parameter int LMEM_DEPTH = scaler_pkg::LINE_BYTES,
   parameter int DEPTH = scaler_pkg::FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Video input ports.
   input wire scaler_pkg::port_in_t port_a,
   input wire scaler_pkg::port_in_t port_b,
   output logic in_ready,
   // Scaled output stream.
   output logic out_valid,
   input wire logic out_ready,
   output scaler_pkg::pix_out_t out_pix
);
   if (LMEM_DEPTH < 768 || LMEM_DEPTH > 1024 || DEPTH < 4) begin : g_check
      $error("video_scaler needs 768..1024 line bytes and a fifo of at least 4");
   end

   logic [31:0] source_q;
   logic [31:0] vscale_q;
   logic [31:0] mode_q;
   logic [31:0] status;
   logic [31:0] rd_data;
   logic bus_req;

   // Register file.
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         source_q <= scaler_pkg::SOURCE_RESET;
         vscale_q <= scaler_pkg::VSCALE_RESET;
         mode_q <= scaler_pkg::MODE_RESET;
      end else if (bus_req && wb_we_i) begin
         if (wb_adr_i == scaler_pkg::ADDR_SOURCE) begin
            source_q <= merge(source_q, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == scaler_pkg::ADDR_VSCALE) begin
            vscale_q <= merge(vscale_q, wb_dat_i, wb_sel_i) & 32'hffff_fffe;
         end else if (wb_adr_i == scaler_pkg::ADDR_MODE) begin
            mode_q <= merge(mode_q, wb_dat_i, wb_sel_i);
         end
      end
   end

   always_comb begin
      if (wb_adr_i == scaler_pkg::ADDR_SOURCE) begin
         rd_data = source_q;
      end else if (wb_adr_i == scaler_pkg::ADDR_VSCALE) begin
         rd_data = vscale_q;
      end else if (wb_adr_i == scaler_pkg::ADDR_MODE) begin
         rd_data = {6'h00, mode_q[scaler_pkg::LLEN_HI:scaler_pkg::LLEN_LO],
                    12'h000, mode_q[scaler_pkg::RMODE_HI:scaler_pkg::RMODE_LO], 2'h0};
      end else if (wb_adr_i == scaler_pkg::ADDR_STATUS) begin
         rd_data = status;
      end else begin
         rd_data = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
      end
   end

   // Field decode.
   logic [1:0] data_sel;
   logic mirror_req;
   logic sync_sel;
   logic [11:0] vstart;
   logic arith_acc;
   logic [9:0] vinc;
   logic [5:0] acc_len;
   logic [6:0] odd_phase;
   logic [6:0] even_phase;
   logic [9:0] line_len;
   scaler_pkg::read_mode_t rmode;
   logic mirror_on;

   assign data_sel = source_q[scaler_pkg::SRC_SEL_HI:scaler_pkg::SRC_SEL_LO];
   assign mirror_req = source_q[scaler_pkg::MIRROR_BIT];
   assign sync_sel = source_q[scaler_pkg::SYNC_SEL_BIT];
   assign vstart = source_q[scaler_pkg::VSTART_HI:scaler_pkg::VSTART_LO];
   assign arith_acc = vscale_q[scaler_pkg::ARITH_BIT];
   assign vinc = vscale_q[scaler_pkg::INC_HI:scaler_pkg::INC_LO];
   assign acc_len = vscale_q[scaler_pkg::ACCLEN_HI:scaler_pkg::ACCLEN_LO];
   assign odd_phase = vscale_q[scaler_pkg::ODDPH_HI:scaler_pkg::ODDPH_LO];
   assign even_phase = vscale_q[scaler_pkg::EVENPH_HI:scaler_pkg::EVENPH_LO];
   assign line_len = mode_q[scaler_pkg::LLEN_HI:scaler_pkg::LLEN_LO];
   assign rmode = scaler_pkg::read_mode_t'(mode_q[scaler_pkg::RMODE_HI:scaler_pkg::RMODE_LO]);
   // A longer line would overrun the column range that the sink reserves, so mirroring drops out.
   assign mirror_on = mirror_req && (line_len < scaler_pkg::MIRROR_LIMIT);

   // Source selection.
   scaler_pkg::port_in_t luma_p;
   scaler_pkg::port_in_t chroma_p;
   scaler_pkg::port_in_t sync_p;

   always_comb begin
      case (data_sel)
         2'h0: begin
            luma_p = port_a;
            chroma_p = port_a;
         end
         2'h1: begin
            luma_p = port_b;
            chroma_p = port_b;
         end
         2'h2: begin
            luma_p = port_b;
            chroma_p = port_a;
         end
         default: begin
            luma_p = port_a;
            chroma_p = port_b;
         end
      endcase
      sync_p = sync_sel ? port_b : port_a;
   end

   // Sync edges and line window.
   logic hs_prev_q;
   logic vs_prev_q;
   logic hs_edge;
   logic vs_edge;
   logic [11:0] line_cnt_q;
   logic field_q;
   logic act_q;
   logic emit_line_q;
   logic first_acc_q;
   logic [9:0] weight_q;
   logic [10:0] pos_q;
   logic [5:0] seq_q;
   logic [5:0] seq_last;

   assign hs_edge = sync_p.hsync && !hs_prev_q;
   assign vs_edge = sync_p.vsync && !vs_prev_q;
   assign seq_last = (acc_len == 6'h00) ? 6'h00 : acc_len - 6'h01;
   assign status = {4'h0, line_cnt_q, 2'h0, act_q, emit_line_q, field_q, pos_q};

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         hs_prev_q <= 1'b0;
         vs_prev_q <= 1'b0;
         line_cnt_q <= 12'h000;
         field_q <= 1'b0;
      end else begin
         hs_prev_q <= sync_p.hsync;
         vs_prev_q <= sync_p.vsync;
         if (vs_edge) begin
            line_cnt_q <= 12'h000;
            field_q <= sync_p.field;
         end else if (hs_edge && line_cnt_q != 12'hfff) begin
            line_cnt_q <= line_cnt_q + 12'h001;
         end
      end
   end

   // Per-line vertical decision, taken at each line start inside the window.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         act_q <= 1'b0;
         emit_line_q <= 1'b0;
         first_acc_q <= 1'b0;
         weight_q <= 10'h000;
         pos_q <= 11'h000;
         seq_q <= 6'h00;
      end else if (vs_edge) begin
         act_q <= 1'b0;
         emit_line_q <= 1'b0;
         seq_q <= 6'h00;
         pos_q <= {1'b0, (sync_p.field ? odd_phase : even_phase), 3'h0};
      end else if (hs_edge) begin
         act_q <= line_cnt_q >= vstart;
         if (line_cnt_q < vstart) begin
            emit_line_q <= 1'b0;
         end else if (arith_acc) begin
            first_acc_q <= seq_q == 6'h00;
            emit_line_q <= seq_q == seq_last;
            seq_q <= (seq_q == seq_last) ? 6'h00 : seq_q + 6'h01;
         end else if (pos_q < scaler_pkg::PHASE_ONE) begin
            emit_line_q <= 1'b1;
            weight_q <= pos_q[9:0];
            pos_q <= pos_q + {1'b0, vinc};
         end else begin
            emit_line_q <= 1'b0;
            pos_q <= pos_q - scaler_pkg::PHASE_ONE;
         end
      end
   end

   // Byte capture stage.
   logic tick;
   logic qual;
   logic is_chroma;
   logic [7:0] sel_byte;
   logic s1_valid_q;
   logic s1_qual_q;
   logic s1_chroma_q;
   logic [7:0] s1_data_q;
   logic [7:0] last_luma_q;
   logic [7:0] last_chroma_q;
   logic [9:0] col_q;
   logic direct;

   assign direct = rmode == scaler_pkg::RM_DIRECT_REPEAT || rmode == scaler_pkg::RM_DIRECT_GREY;
   assign tick = sync_p.line_clock && in_ready;
   assign is_chroma = chroma_p.chroma_reference;
   assign sel_byte = is_chroma ? chroma_p.data : luma_p.data;
   assign qual = is_chroma ? chroma_p.qual : luma_p.qual;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s1_valid_q <= 1'b0;
         s1_qual_q <= 1'b0;
         s1_chroma_q <= 1'b0;
         s1_data_q <= 8'h00;
      end else begin
         s1_valid_q <= tick && act_q && (qual || direct);
         s1_qual_q <= qual;
         s1_chroma_q <= is_chroma;
         s1_data_q <= sel_byte;
      end
   end

   // Vertical arithmetic on one byte against the stored line.
   logic [13:0] lmem [LMEM_DEPTH];
   logic [13:0] stored;
   logic [7:0] cur;
   logic [13:0] acc_sum;
   logic [18:0] interp;
   logic [7:0] result;
   logic col_ok;
   logic push;
   logic fifo_ready;
   logic [$clog2(DEPTH):0] fifo_level;
   scaler_pkg::pix_out_t push_pix;

   assign col_ok = {1'b0, col_q} < 11'(LMEM_DEPTH);
   assign stored = col_ok ? lmem[col_q] : 14'h0000;

   always_comb begin
      if (s1_qual_q) begin
         cur = s1_data_q;
      end else if (rmode == scaler_pkg::RM_DIRECT_GREY) begin
         cur = s1_chroma_q ? scaler_pkg::GREY_CHROMA : scaler_pkg::GREY_LUMA;
      end else begin
         cur = s1_chroma_q ? last_chroma_q : last_luma_q;
      end
      acc_sum = (first_acc_q ? 14'h0000 : stored) + {6'h00, cur};
      interp = 19'(stored[7:0]) * 19'(11'h400 - {1'b0, weight_q})
             + 19'(cur) * 19'({1'b0, weight_q});
      // Gain renormalisation lives elsewhere; the sum saturates to one byte here.
      if (arith_acc) begin
         result = (acc_sum[13:8] != 6'h00) ? 8'hff : acc_sum[7:0];
      end else begin
         result = interp[17:10];
      end
      push_pix.data = result;
      push_pix.col = mirror_on ? 10'({line_len, 1'b0} - 11'h001 - {1'b0, col_q}) : col_q;
      push_pix.chroma = s1_chroma_q;
      push_pix.field = (rmode == scaler_pkg::RM_FIELD) ? field_q : 1'b0;
   end

   assign push = s1_valid_q && emit_line_q;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         col_q <= 10'h000;
         last_luma_q <= scaler_pkg::GREY_LUMA;
         last_chroma_q <= scaler_pkg::GREY_CHROMA;
      end else begin
         if (hs_edge) begin
            col_q <= 10'h000;
         end else if (s1_valid_q && col_q != 10'h3ff) begin
            col_q <= col_q + 10'h001;
         end
         if (s1_valid_q) begin
            if (s1_chroma_q) begin
               last_chroma_q <= cur;
            end else begin
               last_luma_q <= cur;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (s1_valid_q && col_ok) begin
         lmem[col_q] <= arith_acc ? acc_sum : {6'h00, cur};
      end
   end

   // Output buffer; ready is registered, so three free slots cover the bytes still in flight.
   logic fifo_out_valid;
   logic fifo_take;
   scaler_pkg::pix_out_t fifo_pix;

   scaler_fifo #(
      .WIDTH($bits(scaler_pkg::pix_out_t)),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(push_pix),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_take),
      .out_data(fifo_pix),
      .level(fifo_level)
   );

   assign fifo_take = !out_valid || out_ready;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         in_ready <= 1'b0;
         out_valid <= 1'b0;
         out_pix <= '0;
      end else begin
         in_ready <= fifo_level <= ($clog2(DEPTH)+1)'(DEPTH - 3);
         if (fifo_take) begin
            out_valid <= fifo_out_valid;
            out_pix <= fifo_pix;
         end
      end
   end

   AST_SRC_A: assert property (@(posedge clk_sys) disable iff (!resetn)
      data_sel == 2'h0 |-> sel_byte == port_a.data) else $error("source 00 not port A");
   AST_SRC_SPLIT: assert property (@(posedge clk_sys) disable iff (!resetn)
      data_sel == 2'h2 |-> is_chroma == port_a.chroma_reference)
      else $error("split source chroma ref not from chroma port");
   AST_MIRROR: assert property (@(posedge clk_sys) disable iff (!resetn)
      push && !mirror_on |-> push_pix.col == col_q) else $error("column moved unmirrored");
   AST_SYNC: assert property (@(posedge clk_sys) disable iff (!resetn)
      sync_sel |-> sync_p.hsync == port_b.hsync) else $error("sync source wrong");
   AST_WINDOW: assert property (@(posedge clk_sys) disable iff (!resetn)
      s1_valid_q |-> $past(act_q)) else $error("byte outside vertical window");
   AST_VSYNC_PHASE: assert property (@(posedge clk_sys) disable iff (!resetn)
      vs_edge && sync_p.field |=> pos_q == {1'b0, $past(odd_phase), 3'h0})
      else $error("odd start phase not reloaded");
   AST_EVEN_PHASE: assert property (@(posedge clk_sys) disable iff (!resetn)
      vs_edge && !sync_p.field |=> pos_q == {1'b0, $past(even_phase), 3'h0})
      else $error("even start phase not reloaded");
   AST_STEP: assert property (@(posedge clk_sys) disable iff (!resetn)
      hs_edge && !vs_edge && act_q && !arith_acc && pos_q < scaler_pkg::PHASE_ONE
      && line_cnt_q >= vstart |=> pos_q == $past(pos_q) + {1'b0, $past(vinc)})
      else $error("phase step wrong");
   AST_ACC_CLEAR: assert property (@(posedge clk_sys) disable iff (!resetn)
      hs_edge && !vs_edge && arith_acc && line_cnt_q >= vstart && seq_q == 6'h00
      |=> first_acc_q) else $error("accumulator not cleared at sequence start");
   AST_NO_OVERFLOW: assert property (@(posedge clk_sys) disable iff (!resetn)
      push |-> fifo_ready) else $error("push into full fifo");
   AST_GREY: assert property (@(posedge clk_sys) disable iff (!resetn)
      s1_valid_q && !s1_qual_q && rmode == scaler_pkg::RM_DIRECT_GREY && !s1_chroma_q
      |-> cur == scaler_pkg::GREY_LUMA) else $error("grey fill wrong");
   COV_MIRROR: cover property (@(posedge clk_sys) disable iff (!resetn) push && mirror_on);
   COV_ACC_EMIT: cover property (@(posedge clk_sys) disable iff (!resetn) push && arith_acc);
   COV_FULL: cover property (@(posedge clk_sys) disable iff (!resetn) !fifo_ready);
endmodule

`default_nettype wire

// ---- design/scaler_pkg.sv ----
// Purpose: Shared constants and carriers for the video scaler source and vertical scale block.
// Assumes: Wishbone classic slave with 32-bit data; all video inputs are synchronous to clk_sys.
// Notes: Behaviour list follows.
// Behaviour
// - Source field bits 31:30 at 0x5c picks port A (00) or port B (01) for all bytes.
// - Code 10 takes luma from B and chroma from A, code 11 luma from A and chroma from B.
// - Bit 29 mirrors each line, allowed only while the prescaled line length is below 384.
// - Bit 28 picks port A or port B syncs and line clock.
// - Bits 23:12 give the first processed line, counted in line starts after vertical sync.
// - Bit 31 at 0x60 picks linear phase interpolation (0) or accumulating filter (1).
// - Bits 30:21 hold the vertical increment, programmed as 1024 times (in/out minus one).
// - Bits 20:15 give the accumulation sequence length, chosen to fit the scale factor.
// - Bits 14:8 give the odd field start phase in 128ths of a line spacing.
// - Bits 7:1 give the even field start phase in the same scale, bit 0 reserved.
// - Read mode 00 is line memory, 01 field memory, 10 and 11 the direct modes.
package scaler_pkg;
   localparam logic [7:0] ADDR_SOURCE = 8'h5c;
   localparam logic [7:0] ADDR_VSCALE = 8'h60;
   localparam logic [7:0] ADDR_MODE = 8'h68;
   localparam logic [7:0] ADDR_STATUS = 8'h6c;
   localparam int SRC_SEL_HI = 31;
   localparam int SRC_SEL_LO = 30;
   localparam int MIRROR_BIT = 29;
   localparam int SYNC_SEL_BIT = 28;
   localparam int VSTART_HI = 23;
   localparam int VSTART_LO = 12;
   localparam int ARITH_BIT = 31;
   localparam int INC_HI = 30;
   localparam int INC_LO = 21;
   localparam int ACCLEN_HI = 20;
   localparam int ACCLEN_LO = 15;
   localparam int ODDPH_HI = 14;
   localparam int ODDPH_LO = 8;
   localparam int EVENPH_HI = 7;
   localparam int EVENPH_LO = 1;
   localparam int RMODE_HI = 3;
   localparam int RMODE_LO = 2;
   localparam int LLEN_HI = 25;
   localparam int LLEN_LO = 16;
   localparam logic [31:0] SOURCE_RESET = 32'h0000_0000;
   localparam logic [31:0] VSCALE_RESET = 32'h0000_0000;
   localparam logic [31:0] MODE_RESET = 32'h0000_0000;
   localparam logic [9:0] MIRROR_LIMIT = 10'h180;
   localparam logic [10:0] PHASE_ONE = 11'h400;
   localparam logic [7:0] GREY_LUMA = 8'h10;
   localparam logic [7:0] GREY_CHROMA = 8'h80;
   localparam logic [7:0] HOFF_RATIO_1_2 = 8'h0c;
   localparam logic [7:0] HOFF_RATIO_4 = 8'h16;
   localparam logic [7:0] HOFF_RATIO_8 = 8'h2e;
   localparam int FIFO_DEPTH = 4;
   localparam int LINE_BYTES = 768;

   typedef enum logic [1:0] {RM_LINE, RM_FIELD, RM_DIRECT_REPEAT, RM_DIRECT_GREY} read_mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic qual;
      logic chroma_reference;
      logic hsync;
      logic vsync;
      logic field;
      logic line_clock;
   } port_in_t;

   typedef struct packed {
      logic [7:0] data;
      logic [9:0] col;
      logic chroma;
      logic field;
   } pix_out_t;
endpackage

// ---- bench/video_sources.sv ----
// Purpose: Two video sources driving the scaler's ports A and B in lock step.
// Assumes: Bytes alternate luma and chroma; a tick is held until in_ready is seen high.
// Notes: Between ticks the data lines show the inverse of the last byte.
`timescale 1ns/100ps
`default_nettype none
module video_sources (
   // Clock and flow control.
   input wire logic clk_sys,
   input wire logic in_ready,
   // Source ports.
   output scaler_pkg::port_in_t port_a,
   output scaler_pkg::port_in_t port_b
);
   logic fld;
   // Set by the bench to offer unqualified bytes for the direct read modes.
   logic unq;
   initial begin
      port_a = '0;
      port_b = '0;
      fld = 1'b0;
      unq = 1'b0;
   end
   // Port B bytes differ from port A so that a wrong source shows in the data.
   task automatic put(input logic [1:0] en, input logic hs, input logic vs, input logic tk,
                      input logic cr, input logic [7:0] b);
      port_a <= '{tk ? b + 8'(cr) : ~port_a.data, tk & ~unq, cr, hs & en[0], vs & en[0], fld,
                  tk & en[0]};
      port_b <= '{tk ? (b ^ 8'h10) + 8'(cr) : ~port_b.data, tk & ~unq, cr, hs & en[1],
                  vs & en[1], fld, tk & en[1]};
   endtask
   task automatic frame(input logic [1:0] en, input logic f);
      fld = f;
      put(en, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
      @(posedge clk_sys);
      put(en, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic line(input logic [1:0] en, input int n, input logic [7:0] b);
      put(en, 1'b1, 1'b0, 1'b0, 1'b0, b);
      @(posedge clk_sys);
      put(en, 1'b0, 1'b0, 1'b0, 1'b0, b);
      repeat (3) @(posedge clk_sys);
      for (int k = 0; k < n; k++) begin
         put(en, 1'b0, 1'b0, 1'b1, k[0], b);
         do begin
            @(posedge clk_sys);
         end while (in_ready !== 1'b1);
      end
      put(en, 1'b0, 1'b0, 1'b0, 1'b0, b);
      @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for source select and vertical scaling.
// Assumes: Output field only in field memory mode; zero start phase outputs the stored line.
// Notes: Each scenario programs only the registers it changes; the rest carry over from earlier scenarios.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic in_ready;
   logic out_valid;
   logic out_ready = 1'b1;
   scaler_pkg::pix_out_t out_pix;
   wire scaler_pkg::port_in_t port_a;
   wire scaler_pkg::port_in_t port_b;
   int n_errors = 0;
   int n_tests = 0;
   int n_out = 0;
   int cycles = 0;
   logic [7:0] last_y;
   logic [7:0] last_c;
   logic [9:0] last_col;
   logic last_f;
   always #2 clk_sys = ~clk_sys;
   video_scaler DUT (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_a(port_a),
      .port_b(port_b), .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
      .out_pix(out_pix));
   video_sources src (.clk_sys(clk_sys), .in_ready(in_ready), .port_a(port_a),
      .port_b(port_b));
   always @(posedge clk_sys) begin
      if (resetn && out_valid === 1'b1 && out_ready) begin
         n_out <= n_out + 1;
         last_col <= out_pix.col;
         last_f <= out_pix.field;
         if (out_pix.chroma) last_c <= out_pix.data;
         else last_y <= out_pix.data;
      end
   end
   // The ceiling sits well above the under one thousand cycles the scenarios need.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, q);
   endtask
   task automatic two_lines(input logic [7:0] b1, input logic [7:0] b2);
      src.line(2'b11, 4, b1);
      src.line(2'b11, 4, b2);
      repeat (8) @(posedge clk_sys);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      rd(8'h5c, q);
      check(q, 32'h0);
      rd(8'h60, q);
      check(q, 32'h0);
      wr(8'h60, 32'hffff_ffff);
      rd(8'h60, q);
      check(q, 32'hffff_fffe);
      wr(8'h5c, 32'hffff_ffff);
      rd(8'h5c, q);
      check(q, 32'hffff_ffff);
      rd(8'h70, q);
      check(q, 32'h0);
      wr(8'h60, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_source();
      for (int c = 0; c < 4; c++) begin
         wr(8'h5c, {c[1:0], 30'h0});
         src.frame(2'b11, 1'b0);
         two_lines(8'ha0, 8'ha0);
         check(32'(last_y), (c == 1 || c == 2) ? 32'hb0 : 32'ha0);
         check(32'(last_c), c[0] ? 32'hb1 : 32'ha1);
      end
      $display("test source done");
   endtask
   task automatic t_sync();
      int n0;
      wr(8'h5c, 32'h4000_0000);
      src.frame(2'b10, 1'b0);
      n0 = n_out;
      src.line(2'b10, 4, 8'ha0);
      repeat (8) @(posedge clk_sys);
      check(32'(n_out), 32'(n0));
      wr(8'h5c, 32'h5000_0000);
      src.frame(2'b10, 1'b0);
      src.line(2'b10, 4, 8'ha0);
      repeat (8) @(posedge clk_sys);
      check(32'(n_out), 32'(n0 + 4));
      $display("test sync done");
   endtask
   task automatic t_start();
      int n0;
      wr(8'h5c, 32'h0000_2000);
      src.frame(2'b11, 1'b0);
      n0 = n_out;
      // Start line 2 skips the first two lines after vertical sync.
      two_lines(8'ha0, 8'ha0);
      check(32'(n_out), 32'(n0));
      src.line(2'b11, 4, 8'ha0);
      repeat (8) @(posedge clk_sys);
      check(32'(n_out), 32'(n0 + 4));
      $display("test start done");
   endtask
   task automatic t_mirror();
      wr(8'h5c, 32'h2000_0000);
      wr(8'h68, 32'h0004_0000);
      src.frame(2'b11, 1'b0);
      src.line(2'b11, 1, 8'ha0);
      repeat (8) @(posedge clk_sys);
      check(32'(last_col), 32'h7);
      wr(8'h68, 32'h0180_0000);
      src.line(2'b11, 1, 8'ha0);
      repeat (8) @(posedge clk_sys);
      check(32'(last_col), 32'h0);
      $display("test mirror done");
   endtask
   task automatic t_field();
      logic [23:0] hoff;
      hoff = {scaler_pkg::HOFF_RATIO_1_2, scaler_pkg::HOFF_RATIO_4, scaler_pkg::HOFF_RATIO_8};
      check(32'(hoff), 32'h000c_162e);
      wr(8'h5c, 32'h0);
      wr(8'h68, 32'h4);
      src.frame(2'b11, 1'b1);
      two_lines(8'ha0, 8'ha0);
      check(32'(last_f), 32'h1);
      wr(8'h68, 32'h0);
      src.frame(2'b11, 1'b1);
      two_lines(8'ha0, 8'ha0);
      check(32'(last_f), 32'h0);
      $display("test field done");
   endtask
   task automatic t_vert();
      wr(8'h60, 32'h0000_4000);
      src.frame(2'b11, 1'b1);
      two_lines(8'h20, 8'h40);
      check(32'(last_y), 32'h30);
      wr(8'h60, 32'hc001_0000);
      src.frame(2'b11, 1'b0);
      two_lines(8'h20, 8'h40);
      check(32'(last_y), 32'h60);
      wr(8'h60, 32'h0);
      $display("test vertical done");
   endtask
   task automatic t_direct();
      int n0;
      src.unq <= 1'b1;
      wr(8'h68, 32'hc);
      src.frame(2'b11, 1'b0);
      two_lines(8'ha0, 8'ha0);
      check(32'({last_y, last_c}), 32'h1080);
      wr(8'h68, 32'h0);
      n0 = n_out;
      two_lines(8'ha0, 8'ha0);
      check(32'(n_out), 32'(n0));
      src.unq <= 1'b0;
      $display("test direct done");
   endtask
   // The sink stalls so the buffer must fill and push back on the sources.
   task automatic t_fill();
      int n0;
      n0 = n_out;
      out_ready <= 1'b0;
      fork
         src.line(2'b11, 8, 8'ha0);
      join_none
      repeat (40) @(posedge clk_sys);
      check(32'(in_ready), 32'h0);
      out_ready <= 1'b1;
      wait fork;
      repeat (12) @(posedge clk_sys);
      check(32'(n_out), 32'(n0 + 8));
      $display("test fill done");
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_source();
      t_sync();
      t_start();
      t_mirror();
      t_field();
      t_vert();
      t_direct();
      t_fill();
      print_verdict();
   end
endmodule
`default_nettype wire
